/* File: rtl/phy_reset_pkg.sv */
package phy_reset_pkg;

  // bus geometry and register byte offsets
  localparam int          ADDR_W          = 4;
  localparam int          DATA_W          = 32;
  localparam logic [3:0]  OFS_HW_CONFIG   = 4'h0;
  localparam logic [3:0]  OFS_IRQ_STATUS  = 4'h4;
  localparam logic [3:0]  OFS_IRQ_MASK    = 4'h8;

  // hardware_config field positions
  localparam int          BIT_TRIGGER     = 0;
  localparam int          BIT_TIMEOUT     = 1;
  localparam int          BIT_SELECT      = 2;
  localparam int          BIT_PRESENCE    = 3;

  // interrupt status / mask bit positions
  localparam int          IRQ_DONE        = 0;
  localparam int          IRQ_TIMEOUT     = 1;

  // values after reset
  localparam logic        SELECT_RST      = 1'b0;
  localparam logic        TIMEOUT_RST     = 1'b0;
  localparam logic [1:0]  IRQ_STATUS_RST  = 2'h0;
  localparam logic [1:0]  IRQ_MASK_RST    = 2'h0;

  // timing
  localparam int          CLK_PERIOD_NS   = 10;
  localparam int          CLK_WAIT_NS     = 10000;
  localparam int          CLK_WAIT_CYCLES = CLK_WAIT_NS / CLK_PERIOD_NS;
  localparam int          APPLY_CYCLES    = 16;
  localparam logic [1:0]  STRAP_DELAY     = 2'h3;

  // reset sequencer states
  typedef enum logic [1:0] {
    st_idle,
    st_wait_clk,
    st_apply
  } seq_state_type;

  // hardware_config word as seen by software
  typedef struct packed {
    logic [27:0] reserved;
    logic        presence;
    logic        select;
    logic        timeout;
    logic        trigger;
  } hw_config_type;

  // soft reset fan-out to the rest of the controller
  typedef struct packed {
    logic mac_csr_reset;
    logic system_command_status_registers_reset;
    logic error_clear;
  } reset_out_type;

endpackage

/* File: rtl/phy_select_soft_reset_ctrl.sv */
// Implementation choices: the register addresses and the Avalon-MM interface to the registers.
module phy_select_soft_reset_ctrl
  import phy_reset_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic [ADDR_W-1:0] address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [DATA_W-1:0] writedata,
  input  wire logic [3:0]        byteenable,
  output logic      [DATA_W-1:0] readdata,
  output logic                   waitrequest,
  input  wire logic              mdio_in,
  input  wire logic              rx_clk_running,
  input  wire logic              tx_clk_running,
  input  wire logic              power_return,
  output logic                   ext_mii_enable,
  output logic                   int_phy_enable,
  output reset_out_type          reset_out,
  output logic                   irq
);

  // two-stage synchronisers: mdio, rx clock alive, tx clock alive
  logic [2:0]        sync1_reg;
  logic [2:0]        sync2_reg;
  logic              mdio_sync;
  logic              clocks_ok;

  logic              ack_reg, ack_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic              lock_reg, lock_next;
  logic              presence_reg, presence_next;
  logic [1:0]        strap_cnt_reg, strap_cnt_next;
  logic              select_reg, select_next;
  logic              timeout_reg, timeout_next;
  logic [1:0]        status_reg, status_next;
  logic [1:0]        mask_reg, mask_next;
  seq_state_type     state_reg, state_next;
  logic [9:0]        wait_cnt_reg, wait_cnt_next;
  logic [3:0]        apply_cnt_reg, apply_cnt_next;
  reset_out_type     rst_out_reg, rst_out_next;
  logic [10:0]       busy_cnt_reg, busy_cnt_next;

  logic              bus_take;
  logic              wr_ok;
  logic              trig_wr;
  logic              ev_done;
  logic              ev_timeout;
  hw_config_type     cfg_view;

  // first stage is read only by the second
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
    end else begin
      sync1_reg <= {tx_clk_running, rx_clk_running, mdio_in};
      sync2_reg <= sync1_reg;
    end
  end

  assign mdio_sync = sync2_reg[0];
  assign clocks_ok = sync2_reg[1] & sync2_reg[2];

  // a request is taken in its first cycle and answered one cycle later
  assign bus_take    = (read | write) & ~ack_reg;
  assign waitrequest = (read | write) & ~ack_reg;
  assign readdata    = rdata_reg;
  // locked writes are acknowledged but dropped
  assign wr_ok       = bus_take & write & ~lock_reg & byteenable[0];
  assign trig_wr     = wr_ok & (address == OFS_HW_CONFIG) & writedata[BIT_TRIGGER];

  always_comb begin
    cfg_view          = '0;
    cfg_view.presence = presence_reg;
    cfg_view.select   = select_reg;
    cfg_view.timeout  = timeout_reg;
    cfg_view.trigger  = (state_reg != st_idle);
  end

  // bus slave, write lock and strap capture
  always_comb begin
    ack_next       = bus_take;
    rdata_next     = rdata_reg;
    lock_next      = lock_reg;
    presence_next  = presence_reg;
    strap_cnt_next = strap_cnt_reg;
    if (bus_take && read) begin
      case (address)
        OFS_HW_CONFIG:  rdata_next = cfg_view;
        OFS_IRQ_STATUS: rdata_next = {30'h0, status_reg};
        OFS_IRQ_MASK:   rdata_next = {30'h0, mask_reg};
        default:        rdata_next = 32'h0;
      endcase
      lock_next = 1'b0;
    end
    // wake and soft reset completion re-arm the lock; set wins over the read
    if (power_return || ev_done) begin
      lock_next = 1'b1;
    end
    // wait for the synchroniser to fill, then sample once
    if (strap_cnt_reg != STRAP_DELAY) begin
      strap_cnt_next = strap_cnt_reg + 2'h1;
      if (strap_cnt_reg == STRAP_DELAY - 2'h1) begin
        presence_next = mdio_sync;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ack_reg       <= 1'b0;
      rdata_reg     <= 32'h0;
      lock_reg      <= 1'b1;
      presence_reg  <= 1'b0;
      strap_cnt_reg <= 2'h0;
    end else begin
      ack_reg       <= ack_next;
      rdata_reg     <= rdata_next;
      lock_reg      <= lock_next;
      presence_reg  <= presence_next;
      strap_cnt_reg <= strap_cnt_next;
    end
  end

  // soft reset sequencer: wait for phy clocks, then drive the reset fan-out
  always_comb begin
    state_next     = state_reg;
    wait_cnt_next  = wait_cnt_reg;
    apply_cnt_next = apply_cnt_reg;
    timeout_next   = timeout_reg;
    rst_out_next   = '0;
    ev_done        = 1'b0;
    ev_timeout     = 1'b0;
    case (state_reg)
      st_idle: begin
        if (trig_wr) begin
          state_next    = st_wait_clk;
          wait_cnt_next = 10'h0;
          timeout_next  = 1'b0;
        end
      end
      st_wait_clk: begin
        if (clocks_ok) begin
          state_next               = st_apply;
          apply_cnt_next           = 4'h0;
          rst_out_next.error_clear = 1'b1;
        end else if (wait_cnt_reg == 10'(CLK_WAIT_CYCLES - 1)) begin
          state_next   = st_idle;
          timeout_next = 1'b1;
          ev_timeout   = 1'b1;
        end else begin
          wait_cnt_next = wait_cnt_reg + 10'h1;
        end
      end
      st_apply: begin
        // unaffected-by-soft-reset bits are the receiving registers' concern
        rst_out_next.mac_csr_reset = 1'b1;
        rst_out_next.system_command_status_registers_reset    = 1'b1;
        if (apply_cnt_reg == 4'(APPLY_CYCLES - 1)) begin
          state_next = st_idle;
          ev_done    = 1'b1;
        end else begin
          apply_cnt_next = apply_cnt_reg + 4'h1;
        end
      end
      default: state_next = st_idle;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_reg     <= st_idle;
      wait_cnt_reg  <= 10'h0;
      apply_cnt_reg <= 4'h0;
      timeout_reg   <= TIMEOUT_RST;
      rst_out_reg   <= '0;
    end else begin
      state_reg     <= state_next;
      wait_cnt_reg  <= wait_cnt_next;
      apply_cnt_reg <= apply_cnt_next;
      timeout_reg   <= timeout_next;
      rst_out_reg   <= rst_out_next;
    end
  end

  assign reset_out = rst_out_reg;

  // port select, mask and sticky status; hardware set beats software clear
  always_comb begin
    select_next = select_reg;
    mask_next   = mask_reg;
    status_next = status_reg;
    if (wr_ok && address == OFS_HW_CONFIG) begin
      select_next = writedata[BIT_SELECT];
    end
    if (wr_ok && address == OFS_IRQ_MASK) begin
      mask_next = writedata[1:0];
    end
    if (wr_ok && address == OFS_IRQ_STATUS) begin
      status_next = status_reg & ~writedata[1:0];
    end
    status_next[IRQ_DONE]    = status_next[IRQ_DONE] | ev_done;
    status_next[IRQ_TIMEOUT] = status_next[IRQ_TIMEOUT] | ev_timeout;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      select_reg <= SELECT_RST;
      mask_reg   <= IRQ_MASK_RST;
      status_reg <= IRQ_STATUS_RST;
    end else begin
      select_reg <= select_next;
      mask_reg   <= mask_next;
      status_reg <= status_next;
    end
  end

  // select steers only the data-path enables, never smi or clock muxes
  assign ext_mii_enable = select_reg;
  assign int_phy_enable = ~select_reg;
  assign irq            = |(status_reg & mask_reg);

  // checks
  a_strap_held: assert property (@(posedge clk) disable iff (!nrst)
    (strap_cnt_reg == STRAP_DELAY) |=> $stable(presence_reg))
    else $error("presence strap changed after capture");

  a_strap_value: assert property (@(posedge clk) disable iff (!nrst)
    (strap_cnt_reg == STRAP_DELAY - 2'h1) |=> (presence_reg == $past(mdio_sync)))
    else $error("presence strap does not match mdio");

  a_strap_isolated: assert property (@(posedge clk) disable iff (!nrst)
    $changed(presence_reg) |-> (state_reg == st_idle) && $stable(select_reg))
    else $error("presence strap disturbed other logic");

  a_select_write: assert property (@(posedge clk) disable iff (!nrst)
    (wr_ok && address == OFS_HW_CONFIG) |=> ext_mii_enable == $past(writedata[BIT_SELECT])
      && int_phy_enable != ext_mii_enable)
    else $error("select write not applied to port enables");

  a_timeout_flag: assert property (@(posedge clk) disable iff (!nrst)
    (state_reg == st_wait_clk && !clocks_ok && wait_cnt_reg == 10'(CLK_WAIT_CYCLES - 1))
      |=> timeout_reg && state_reg == st_idle && !reset_out.mac_csr_reset)
    else $error("timeout not flagged");

  a_reset_fanout: assert property (@(posedge clk) disable iff (!nrst)
    (state_reg == st_wait_clk && clocks_ok) |=> reset_out.error_clear ##1
      (reset_out.mac_csr_reset && reset_out.system_command_status_registers_reset && !reset_out.error_clear) [*8])
    else $error("soft reset fan-out wrong");

  // busy time counter for the self-clear check; too long for a delay range
  // longest legal stay is the whole clock wait followed by the apply window
  always_comb begin
    busy_cnt_next = 11'h0;
    if (state_reg != st_idle) begin
      busy_cnt_next = busy_cnt_reg + 11'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      busy_cnt_reg <= 11'h0;
    end else begin
      busy_cnt_reg <= busy_cnt_next;
    end
  end

  a_trigger_selfclear: assert property (@(posedge clk) disable iff (!nrst)
    busy_cnt_reg <= 11'(CLK_WAIT_CYCLES + APPLY_CYCLES))
    else $error("trigger did not clear itself");

  a_clear_pulse: assert property (@(posedge clk) disable iff (!nrst)
    reset_out.error_clear |=> !reset_out.error_clear)
    else $error("error clear longer than one cycle");

  a_done_relock: assert property (@(posedge clk) disable iff (!nrst)
    ev_done |=> lock_reg)
    else $error("write lock not re-armed after soft reset");

  a_locked_write: assert property (@(posedge clk) disable iff (!nrst)
    (bus_take && write && lock_reg) |=> $stable(select_reg) && $stable(mask_reg))
    else $error("write accepted while locked");

  a_busy_reads_one: assert property (@(posedge clk) disable iff (!nrst)
    (bus_take && read && address == OFS_HW_CONFIG && state_reg != st_idle)
      |=> readdata[BIT_TRIGGER] && !waitrequest)
    else $error("trigger not read as busy");

  c_reset_done:    cover property (@(posedge clk) disable iff (!nrst) ev_done);
  c_reset_timeout: cover property (@(posedge clk) disable iff (!nrst) ev_timeout);
  c_locked_write:  cover property (@(posedge clk) disable iff (!nrst) bus_take && write && lock_reg);
  c_irq_raised:    cover property (@(posedge clk) disable iff (!nrst) $rose(irq));

endmodule

/* File: test/avalon_host_model.sv */
// host side of the register bus: one Avalon-MM word transfer at a time
module avalon_host_model
  import phy_reset_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              waitrequest,
  input  wire logic [DATA_W-1:0] readdata,
  output logic      [ADDR_W-1:0] address,
  output logic                   read,
  output logic                   write,
  output logic      [DATA_W-1:0] writedata,
  output logic      [3:0]        byteenable
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    address    = '0;
    read       = 1'b0;
    write      = 1'b0;
    writedata  = '0;
    byteenable = 4'h0;
  end

  // request held until the edge that sees waitrequest low; ok drops if the slave never answers
  task automatic xfer(input logic rd, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                      output logic [DATA_W-1:0] q, output logic ok);
    int n;
    ok = 1'b0;
    q  = '0;
    @(posedge clk);
    address    <= a;
    read       <= rd;
    write      <= ~rd;
    writedata  <= d;
    byteenable <= 4'hf;
    // waitrequest and readdata are read at the edge itself, before the slave's flops update
    for (n = 0; n < 64; n++) begin
      @(posedge clk);
      if (waitrequest === 1'b0) begin
        q  = readdata;
        ok = 1'b1;
        break;
      end
    end
    read      <= 1'b0;
    write     <= 1'b0;
    writedata <= ~d;
  endtask
endmodule

/* File: test/testbench.sv */
module testbench;
  import phy_reset_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, nrst = 1'b0, mdio_in = 1'b1, rx_clk_running = 1'b0, tx_clk_running = 1'b0;
  logic power_return = 1'b0, waitrequest, ext_mii_enable, int_phy_enable, irq, read, write;
  logic [ADDR_W-1:0] address;
  logic [DATA_W-1:0] writedata, readdata;
  logic [3:0]        byteenable;
  reset_out_type     reset_out;
  int                error_cnt = 0, n_tests = 0, n_mac = 0, n_ec = 0;

  phy_select_soft_reset_ctrl u_dut (.clk(clk), .nrst(nrst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .mdio_in(mdio_in), .rx_clk_running(rx_clk_running),
    .tx_clk_running(tx_clk_running), .power_return(power_return), .ext_mii_enable(ext_mii_enable),
    .int_phy_enable(int_phy_enable), .reset_out(reset_out), .irq(irq));
  avalon_host_model u_host (.clk(clk), .waitrequest(waitrequest), .readdata(readdata),
    .address(address), .read(read), .write(write), .writedata(writedata), .byteenable(byteenable));

  always #5 clk = ~clk;

  // count soft reset pulses mid-cycle, away from the launching edge
  always @(negedge clk) begin
    if (reset_out.mac_csr_reset === 1'b1) n_mac++;
    if (reset_out.error_clear === 1'b1) n_ec++;
  end

  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic stuck();
    error_cnt++;
    results();
  endtask

  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rdv(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] q);
    logic ok;
    u_host.xfer(1'b1, a, '0, q, ok);
    if (ok !== 1'b1) stuck();
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    logic [DATA_W-1:0] q;
    rdv(a, q);
    chk(q, exp);
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] q;
    logic              ok;
    u_host.xfer(1'b0, a, d, q, ok);
    if (ok !== 1'b1) stuck();
  endtask

  // polls the trigger bit; the clock wait alone is about a thousand cycles
  task automatic poll_idle();
    logic [DATA_W-1:0] q;
    for (int i = 0; i < 700; i++) begin
      rdv(OFS_HW_CONFIG, q);
      if (q[BIT_TRIGGER] === 1'b0) return;
    end
    stuck();
  endtask

  task automatic pins(input logic [2:0] exp);
    @(negedge clk);
    chk({29'h0, ext_mii_enable, int_phy_enable, irq}, {29'h0, exp});
  endtask

  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    pins(3'b010);
    wr(OFS_HW_CONFIG, 32'h4);
    rd(OFS_HW_CONFIG, 32'h8);
    wr(OFS_HW_CONFIG, 32'h4);
    pins(3'b100);
    mdio_in <= 1'b0;
    rd(OFS_HW_CONFIG, 32'hc);
    rd(4'hc, 32'h0);
    wr(OFS_IRQ_MASK, 32'h3);
    rd(OFS_IRQ_MASK, 32'h3);
    // no PHY clocks: the request must give up
    wr(OFS_HW_CONFIG, 32'h5);
    rd(OFS_HW_CONFIG, 32'hd);
    poll_idle();
    rd(OFS_HW_CONFIG, 32'he);
    chk(32'(n_mac + n_ec), 32'h0);
    rd(OFS_IRQ_STATUS, 32'h2);
    pins(3'b101);
    wr(OFS_IRQ_STATUS, 32'h2);
    rd(OFS_IRQ_STATUS, 32'h0);
    pins(3'b100);
    rx_clk_running <= 1'b1;
    tx_clk_running <= 1'b1;
    wr(OFS_HW_CONFIG, 32'h5);
    rd(OFS_HW_CONFIG, 32'hd);
    for (int i = 0; i < 200 && irq !== 1'b1; i++) @(negedge clk);
    if (irq !== 1'b1) stuck();
    wr(OFS_HW_CONFIG, 32'h0);
    rd(OFS_HW_CONFIG, 32'hc);
    chk(32'(n_mac), 32'(APPLY_CYCLES));
    chk(32'(n_ec), 32'h1);
    rd(OFS_IRQ_STATUS, 32'h1);
    wr(OFS_IRQ_MASK, 32'h0);
    pins(3'b100);
    wr(OFS_IRQ_STATUS, 32'h1);
    rd(OFS_IRQ_STATUS, 32'h0);
    // a wake from power save locks writes again
    @(posedge clk);
    power_return <= 1'b1;
    @(posedge clk);
    power_return <= 1'b0;
    wr(OFS_HW_CONFIG, 32'h0);
    rd(OFS_HW_CONFIG, 32'hc);
    wr(OFS_HW_CONFIG, 32'h0);
    rd(OFS_HW_CONFIG, 32'h8);
    pins(3'b010);
    // hard reset with the strap pin low must report no external phy
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    rd(OFS_HW_CONFIG, 32'h0);
    results();
  end
endmodule
